// ---- pkg/dcr_pkg.sv ----
// Package of the dual-channel repeater core: levels, modes and timing counts.
// Assumes a single 10 MHz core clock derived from the internal oscillator.
package dcr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin levels: dominant is low on every digital pin
    localparam logic LVL_DOM = 1'b0;
    localparam logic LVL_REC = 1'b1;

    localparam int NUM_CH = 2;
    localparam int CNT_W  = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Timing, as printed or chosen, and derived cycle counts
    localparam int CLK_PERIOD_NS = 100;
    localparam int SUPP_HOLD_NS  = 200;
    localparam int BLOCK_NS      = 50;
    localparam int TIMEOUT_US    = 1000;
    localparam int DEBOUNCE_US   = 10;

    // Least time rounded up to whole cycles, never below one
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SUPP_HOLD_CYC = ceil_cyc(SUPP_HOLD_NS);
    localparam int BLOCK_CYC     = ceil_cyc(BLOCK_NS);
    localparam int TIMEOUT_CYC   = ceil_cyc(TIMEOUT_US * 1000);
    localparam int DEBOUNCE_CYC  = ceil_cyc(DEBOUNCE_US * 1000);

    ////////////////////////////////////////////////////////////////////////////
    // Core operating mode
    typedef enum logic [1:0] {
        ST_POR   = 2'b00,
        ST_START = 2'b01,
        ST_RUN   = 2'b10
    } dcr_mode_t;

endpackage

// ---- rtl/dcr_chan.sv ----
// Per-channel timers: suppression hold, re-drive block, dominant time-out,
// short-to-battery debounce. Instantiated once per bus channel by dcr_core.
// Assumes req, ext_dom and drive_on are synchronous to clock.
`timescale 1ns/1ps
module dcr_chan #(
    parameter int TIMEOUT_CYC  = dcr_pkg::TIMEOUT_CYC,
    parameter int DEBOUNCE_CYC = dcr_pkg::DEBOUNCE_CYC
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic req,
    input  wire logic ext_dom,
    input  wire logic drive_on,
    input  wire logic short_det,
    output logic      hold_active,
    output logic      block_active,
    output logic      expired,
    output logic      bat_off
);

    localparam logic [dcr_pkg::CNT_W-1:0] HOLD_LD  = dcr_pkg::CNT_W'(dcr_pkg::SUPP_HOLD_CYC);
    localparam logic [dcr_pkg::CNT_W-1:0] BLOCK_LD = dcr_pkg::CNT_W'(dcr_pkg::BLOCK_CYC);
    localparam logic [dcr_pkg::CNT_W-1:0] TO_LIM   = dcr_pkg::CNT_W'(TIMEOUT_CYC);
    localparam logic [dcr_pkg::CNT_W-1:0] DEB_LIM  = dcr_pkg::CNT_W'(DEBOUNCE_CYC);
    localparam logic [dcr_pkg::CNT_W-1:0] ZERO     = '0;
    localparam logic [dcr_pkg::CNT_W-1:0] ONE      = dcr_pkg::CNT_W'(1);

    logic [dcr_pkg::CNT_W-1:0] hold_cnt_r,  hold_cnt_nxt;
    logic [dcr_pkg::CNT_W-1:0] block_cnt_r, block_cnt_nxt;
    logic [dcr_pkg::CNT_W-1:0] to_cnt_r,    to_cnt_nxt;
    logic [dcr_pkg::CNT_W-1:0] deb_cnt_r,   deb_cnt_nxt;
    logic                      ext_prev_r,  ext_prev_nxt;
    logic                      expired_r,   expired_nxt;
    logic                      bat_off_r,   bat_off_nxt;
    logic                      ext_fall;
    logic                      trig_n;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        // Time-out trigger is low while a dominant drive is requested
        trig_n   = ~req;
        ext_fall = ext_prev_r & ~ext_dom;
        ext_prev_nxt = ext_dom;

        // Suppression keeps going after the driver lets go
        hold_cnt_nxt = hold_cnt_r;
        if (drive_on)
            hold_cnt_nxt = HOLD_LD;
        else if (hold_cnt_r != ZERO)
            hold_cnt_nxt = hold_cnt_r - ONE;

        // Block re-drive right after an external dominant ends
        block_cnt_nxt = block_cnt_r;
        if (ext_fall)
            block_cnt_nxt = BLOCK_LD - ONE;
        else if (block_cnt_r != ZERO)
            block_cnt_nxt = block_cnt_r - ONE;

        // Trigger high resets the timer; low counts up to the limit
        to_cnt_nxt  = to_cnt_r;
        expired_nxt = expired_r;
        if (trig_n)
        begin
            to_cnt_nxt  = ZERO;
            expired_nxt = 1'b0;
        end
        else if (to_cnt_r < TO_LIM)
            to_cnt_nxt = to_cnt_r + ONE;
        else
            expired_nxt = 1'b1;

        // Debounced short to battery turns this driver off only
        deb_cnt_nxt = ZERO;
        bat_off_nxt = 1'b0;
        if (short_det)
        begin
            deb_cnt_nxt = (deb_cnt_r < DEB_LIM) ? deb_cnt_r + ONE : deb_cnt_r;
            bat_off_nxt = bat_off_r | (deb_cnt_r >= DEB_LIM);
        end

        if (!run)
        begin
            // Counters sit cleared while the core is not running
            hold_cnt_nxt  = ZERO;
            block_cnt_nxt = ZERO;
            to_cnt_nxt    = ZERO;
            deb_cnt_nxt   = ZERO;
            expired_nxt   = 1'b0;
            bat_off_nxt   = 1'b0;
            ext_prev_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            hold_cnt_r  <= '0;
            block_cnt_r <= '0;
            to_cnt_r    <= '0;
            deb_cnt_r   <= '0;
            ext_prev_r  <= 1'b0;
            expired_r   <= 1'b0;
            bat_off_r   <= 1'b0;
        end
        else
        begin
            hold_cnt_r  <= hold_cnt_nxt;
            block_cnt_r <= block_cnt_nxt;
            to_cnt_r    <= to_cnt_nxt;
            deb_cnt_r   <= deb_cnt_nxt;
            ext_prev_r  <= ext_prev_nxt;
            expired_r   <= expired_nxt;
            bat_off_r   <= bat_off_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The falling edge itself blocks at once, so no cycle slips through
    assign hold_active  = hold_cnt_r != ZERO;
    assign block_active = ext_fall | (block_cnt_r != ZERO);
    assign expired      = expired_r;
    assign bat_off      = bat_off_r;

endmodule

// ---- rtl/dcr_core.sv ----
// Repeat logic of a dual bus transceiver: host interface, expansion lines,
// two bus channels with feedback suppression, time-outs and driver shutdown.
// Assumes rst is the power-on reset and all inputs are synchronous to clock.
// Bus comparator inputs are low for dominant; driver outputs are high to drive.
`timescale 1ns/1ps

// Behaviour
// - Dominant on any bus or host transmit goes to both buses and outputs
// - A bus is dominant if any driver is active, recessive otherwise
// - A disabled channel's transmitter stays recessive regardless of inputs
// - A disabled channel's receiver reads recessive; enabled it follows comparator
// - Own-driver dominant seen by a channel's receiver is masked as recessive
// - Suppression starts with the drive request and holds after release
// - Both channels use identical, independent suppression paths of equal priority
// - Skewed release of two external dominants gives no spurious output pulse
// - Driving a channel is blocked briefly after its external dominant ends
// - Digital pins: dominant is low, recessive is high
// - Unconnected digital inputs read high: recessive or disabled
// - Host receive follows host and expansion transmit, regardless of disables
// - Expansion receive is low for host transmit or suppressed bus dominant
// - Low expansion transmit drives both buses and host receive low
// - During power-on reset counters clear, inputs ignored, clock keeps running
// - During power-on reset expansion receive floats, host receive high, buses recessive
// - Trigger low longer than the limit sets expired and forces recessive
// - Trigger rising edge resets the timer and clears expired
// - Over-temperature turns off transmitters only; everything else keeps going
// - Debounced short to battery turns off that channel's driver only
// - A faulty channel does not stop traffic with the healthy channel
module dcr_core #(
    parameter int TIMEOUT_CYC  = dcr_pkg::TIMEOUT_CYC,
    parameter int DEBOUNCE_CYC = dcr_pkg::DEBOUNCE_CYC
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic host_tx_in,
    input  wire logic exp_tx_in,
    input  wire logic channel1_disable,
    input  wire logic channel2_disable,
    input  wire logic bus1_rx_in,
    input  wire logic bus2_rx_in,
    input  wire logic over_temp,
    input  wire logic battery_short_detect1,
    input  wire logic battery_short_detect2,
    output logic      host_rx_out,
    output logic      exp_rx_out,
    output logic      exp_rx_oe,
    output logic      bus1_drive,
    output logic      bus2_drive,
    output logic      timeout_expired1,
    output logic      timeout_expired2
);

    ////////////////////////////////////////////////////////////////////////////
    // Mode: leave power-on reset through one start cycle so every counter is
    // clear before the first input is looked at

    dcr_pkg::dcr_mode_t mode_r, mode_nxt;
    logic               run;

    always_comb
    begin
        case (mode_r)
            dcr_pkg::ST_POR:   mode_nxt = dcr_pkg::ST_START;
            dcr_pkg::ST_START: mode_nxt = dcr_pkg::ST_RUN;
            dcr_pkg::ST_RUN:   mode_nxt = dcr_pkg::ST_RUN;
            default:           mode_nxt = dcr_pkg::ST_POR;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            mode_r <= dcr_pkg::ST_POR;
        else
            mode_r <= mode_nxt;
    end

    assign run = (mode_r == dcr_pkg::ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Input decode: low is dominant; a floating pin is pulled high outside,
    // so it lands here as recessive or as disabled

    function automatic logic is_dom(input logic pin);
        return pin == dcr_pkg::LVL_DOM;
    endfunction

    function automatic logic to_pin(input logic dom);
        return dom ? dcr_pkg::LVL_DOM : dcr_pkg::LVL_REC;
    endfunction

    logic       host_dom;
    logic       exp_dom;
    logic [1:0] ch_dis;
    logic [1:0] rx_raw_dom;

    always_comb
    begin
        // Inputs are ignored until the core runs
        host_dom      = run & is_dom(host_tx_in);
        exp_dom       = run & is_dom(exp_tx_in);
        ch_dis[0]     = ~run | (channel1_disable != 1'b0);
        ch_dis[1]     = ~run | (channel2_disable != 1'b0);
        rx_raw_dom[0] = run & is_dom(bus1_rx_in);
        rx_raw_dom[1] = run & is_dom(bus2_rx_in);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel state and per-channel timers

    logic [1:0] drive_r,   drive_nxt;
    logic [1:0] seen_r,    seen_nxt;
    logic [1:0] rx_dom;
    logic [1:0] req;
    logic [1:0] supp;
    logic [1:0] hold_active;
    logic [1:0] block_active;
    logic [1:0] expired;
    logic [1:0] bat_off;
    logic [1:0] short_det;

    assign short_det = {battery_short_detect2, battery_short_detect1};

    // One identical instance per channel keeps both buses at equal priority
    for (genvar ch = 0; ch < dcr_pkg::NUM_CH; ch++)
    begin : g_chan
        dcr_chan #(
            .TIMEOUT_CYC  (TIMEOUT_CYC),
            .DEBOUNCE_CYC (DEBOUNCE_CYC)
        ) u_chan (
            .clock        (clock),
            .rst          (rst),
            .run          (run),
            .req          (req[ch]),
            .ext_dom      (seen_r[ch]),
            .drive_on     (drive_r[ch]),
            .short_det    (short_det[ch] & run),
            .hold_active  (hold_active[ch]),
            .block_active (block_active[ch]),
            .expired      (expired[ch]),
            .bat_off      (bat_off[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Repeat logic. The cross path uses the registered suppressed receive of
    // the other channel; this breaks the loop through the two suppressors
    // at the cost of one clock of repeat latency.

    always_comb
    begin
        for (int ch = 0; ch < dcr_pkg::NUM_CH; ch++)
        begin
            // Disabled receiver reads recessive, enabled is the comparator
            rx_dom[ch] = rx_raw_dom[ch] & ~ch_dis[ch];

            // Request from host, expansion or the other bus. A bus that is
            // itself a source is not driven from the other, so two external
            // dominants never mask each other and the outputs cannot ring
            req[ch] = host_dom | exp_dom
                    | (seen_r[1 - ch] & ~seen_r[ch]);

            // Suppression is live from the request, through the drive, into
            // the hold; the request term makes it start before the bus moves
            supp[ch] = req[ch] | drive_r[ch] | hold_active[ch];

            seen_nxt[ch] = rx_dom[ch] & ~supp[ch];

            // Each shutdown but over_temp touches only this channel's driver
            drive_nxt[ch] = req[ch]
                          & ~block_active[ch]
                          & ~ch_dis[ch]
                          & ~expired[ch]
                          & ~over_temp
                          & ~bat_off[ch];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            drive_r <= '0;
            seen_r  <= '0;
        end
        else
        begin
            drive_r <= drive_nxt;
            seen_r  <= seen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interface outputs. The receive side never looks at over_temp, the
    // time-outs or the shutdowns, so reception continues under all faults.
    // After both external dominants end, the released channel is still
    // masked by its hold, so the outputs fall back in one clean step.

    logic host_rx_r,  host_rx_nxt;
    logic exp_rx_r,   exp_rx_nxt;
    logic exp_oe_r,   exp_oe_nxt;
    logic [1:0] exp_r, exp_nxt;

    always_comb
    begin
        // Host and expansion transmit reach host receive past both disables
        host_rx_nxt = to_pin(host_dom | exp_dom | (|seen_nxt));

        // Expansion receive excludes expansion transmit to avoid latching
        // two chained devices dominant through each other
        exp_rx_nxt  = to_pin(host_dom | (|seen_nxt));
        exp_oe_nxt  = run;
        exp_nxt     = expired;

        if (!run)
        begin
            host_rx_nxt = dcr_pkg::LVL_REC;
            exp_rx_nxt  = dcr_pkg::LVL_REC;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            host_rx_r <= dcr_pkg::LVL_REC;
            exp_rx_r  <= dcr_pkg::LVL_REC;
            exp_oe_r  <= 1'b0;
            exp_r     <= '0;
        end
        else
        begin
            host_rx_r <= host_rx_nxt;
            exp_rx_r  <= exp_rx_nxt;
            exp_oe_r  <= exp_oe_nxt;
            exp_r     <= exp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Every output comes straight from a flip-flop

    assign host_rx_out      = host_rx_r;
    assign exp_rx_out       = exp_rx_r;
    assign exp_rx_oe        = exp_oe_r;
    assign bus1_drive       = drive_r[0];
    assign bus2_drive       = drive_r[1];
    assign timeout_expired1 = exp_r[0];
    assign timeout_expired2 = exp_r[1];

endmodule

// ---- verif/dcr_bus_model.sv ----
// Far-side model: two wired-dominant bus lines seen through their comparators.
// Assumes drivers are high to drive and the external forcing inputs are low for dominant.
`timescale 1ns/1ps
module dcr_bus_model (
    input  wire logic clock,
    input  wire logic bus1_drive,
    input  wire logic bus2_drive,
    input  wire logic ext1_n,
    input  wire logic ext2_n,
    output logic      bus1_rx_in,
    output logic      bus2_rx_in
);
    ////////////////////////////////////////////////////////////////////////////
    // One cycle of comparator lag, so suppression has to lead the feedback
    always_ff @(posedge clock)
    begin
        bus1_rx_in <= ext1_n & ~bus1_drive;
        bus2_rx_in <= ext2_n & ~bus2_drive;
    end
endmodule

// ---- verif/dcr_core_properties.sv ----
// Checker of dcr_core port behaviour: levels, repeat paths, gating, time-outs.
// Assumes rst is the synchronous power-on reset and one clock for everything.
`timescale 1ns/1ps
module dcr_core_properties #(
    parameter int TIMEOUT_CYC  = dcr_pkg::TIMEOUT_CYC,
    parameter int DEBOUNCE_CYC = dcr_pkg::DEBOUNCE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic host_tx_in,
    input wire logic exp_tx_in,
    input wire logic channel1_disable,
    input wire logic channel2_disable,
    input wire logic bus1_rx_in,
    input wire logic bus2_rx_in,
    input wire logic over_temp,
    input wire logic battery_short_detect1,
    input wire logic battery_short_detect2,
    input wire logic host_rx_out,
    input wire logic exp_rx_out,
    input wire logic exp_rx_oe,
    input wire logic bus1_drive,
    input wire logic bus2_drive,
    input wire logic timeout_expired1,
    input wire logic timeout_expired2
);
    logic [2:0]  age_r;
    logic [15:0] low_run_r;
    logic [15:0] short_run_r;
    logic        live;

    // Margin after reset so the start-up modes never meet an antecedent
    assign live = (age_r == 3'h7);

    always_ff @(posedge clock)
    begin
        age_r       <= rst ? 3'h0 : age_r + {2'h0, ~live};
        low_run_r   <= (rst || host_tx_in) ? 16'h0 : low_run_r + {15'h0, live};
        short_run_r <= (rst || !battery_short_detect1) ? 16'h0 : short_run_r + 16'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence quiet_s;
        live && host_tx_in && exp_tx_in && bus1_rx_in && bus2_rx_in && !over_temp
            && !battery_short_detect1 && !battery_short_detect2;
    endsequence

    sequence bus1_dom_s;
        !bus1_rx_in && !channel1_disable && !channel2_disable && host_tx_in && exp_tx_in
            && !over_temp && bus2_rx_in;
    endsequence

    a_por_outputs: assert property (disable iff (1'b0)
        rst |=> host_rx_out && exp_rx_out && !exp_rx_oe && !bus1_drive && !bus2_drive
            && !timeout_expired1 && !timeout_expired2)
        else $error("outputs not idle during reset");
    a_host_to_bus: assert property (
        quiet_s[*4] ##1 (!host_tx_in && !channel1_disable && !over_temp && !battery_short_detect1)
            |=> bus1_drive && !host_rx_out && !exp_rx_out)
        else $error("host dominant not repeated");
    a_bus_to_bus: assert property (
        quiet_s[*4] ##1 bus1_dom_s[*2] |=> bus2_drive && !host_rx_out && !exp_rx_out)
        else $error("bus dominant not repeated");
    a_disable_tx: assert property (
        (channel1_disable |=> !bus1_drive) and (channel2_disable |=> !bus2_drive))
        else $error("disabled channel drives");
    a_disable_rx: assert property (
        (live && channel1_disable && channel2_disable && host_tx_in && exp_tx_in)[*3]
            |=> host_rx_out && exp_rx_out)
        else $error("disabled receiver reaches outputs");
    a_host_rx_path: assert property (
        live && !(host_tx_in && exp_tx_in) |=> !host_rx_out)
        else $error("host receive misses transmit");
    a_exp_rx_host: assert property (
        live && !host_tx_in |=> !exp_rx_out && exp_rx_oe)
        else $error("expansion receive misses host");
    a_over_temp: assert property (
        over_temp |=> !bus1_drive && !bus2_drive)
        else $error("driver active in over temperature");
    a_idle_level: assert property (
        quiet_s[*4] |=> host_rx_out && exp_rx_out && !bus1_drive && !bus2_drive)
        else $error("dominant without a source");
    a_timeout_set: assert property (
        low_run_r > TIMEOUT_CYC + 4 |-> timeout_expired1 && !bus1_drive && !bus2_drive)
        else $error("dominant time-out missed");
    a_short_off: assert property (
        short_run_r > DEBOUNCE_CYC + 2 |-> !bus1_drive)
        else $error("shorted driver still on");
endmodule

bind dcr_core dcr_core_properties #(.TIMEOUT_CYC(TIMEOUT_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC))
    u_dcr_core_properties (.clock(clock), .rst(rst), .host_tx_in(host_tx_in),
    .exp_tx_in(exp_tx_in), .channel1_disable(channel1_disable),
    .channel2_disable(channel2_disable), .bus1_rx_in(bus1_rx_in), .bus2_rx_in(bus2_rx_in),
    .over_temp(over_temp), .battery_short_detect1(battery_short_detect1),
    .battery_short_detect2(battery_short_detect2), .host_rx_out(host_rx_out),
    .exp_rx_out(exp_rx_out), .exp_rx_oe(exp_rx_oe), .bus1_drive(bus1_drive),
    .bus2_drive(bus2_drive), .timeout_expired1(timeout_expired1),
    .timeout_expired2(timeout_expired2));

// ---- verif/testbench.sv ----
// Self-checking bench of dcr_core: directed corner cases plus random host traffic.
// Assumes dcr_bus_model closes the loop from the drivers back to the comparators.
`timescale 1ns/1ps
module testbench;
    localparam int TO_CYC = 20;
    localparam int DB_CYC = 5;
    logic clock, rst, host_tx_in, exp_tx_in, channel1_disable, channel2_disable, over_temp;
    logic battery_short_detect1, battery_short_detect2, ext1_n, ext2_n, bus1_rx_in, bus2_rx_in;
    logic host_rx_out, exp_rx_out, exp_rx_oe, bus1_drive, bus2_drive;
    logic timeout_expired1, timeout_expired2;
    int   err_total, num_checks;

    dcr_core #(.TIMEOUT_CYC(TO_CYC), .DEBOUNCE_CYC(DB_CYC)) u_dcr_core (.clock(clock),
        .rst(rst), .host_tx_in(host_tx_in), .exp_tx_in(exp_tx_in),
        .channel1_disable(channel1_disable), .channel2_disable(channel2_disable),
        .bus1_rx_in(bus1_rx_in), .bus2_rx_in(bus2_rx_in), .over_temp(over_temp),
        .battery_short_detect1(battery_short_detect1),
        .battery_short_detect2(battery_short_detect2), .host_rx_out(host_rx_out),
        .exp_rx_out(exp_rx_out), .exp_rx_oe(exp_rx_oe), .bus1_drive(bus1_drive),
        .bus2_drive(bus2_drive), .timeout_expired1(timeout_expired1),
        .timeout_expired2(timeout_expired2));
    dcr_bus_model u_dcr_bus_model (.clock(clock), .bus1_drive(bus1_drive),
        .bus2_drive(bus2_drive), .ext1_n(ext1_n), .ext2_n(ext2_n),
        .bus1_rx_in(bus1_rx_in), .bus2_rx_in(bus2_rx_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic check(input string name, input logic [6:0] seen, input logic [6:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Drive expected from host and expansion transmit levels and the disable alone while suppression hides the echo
    function automatic logic drive_exp(input logic h, input logic e, input logic dis);
        return ~(h & e) & ~dis;
    endfunction

    // Read at an edge, so these are the values settled after the edge before
    function automatic logic [6:0] outs();
        return {exp_rx_oe, host_rx_out, exp_rx_out, bus1_drive, bus2_drive,
                timeout_expired1, timeout_expired2};
    endfunction

    task automatic idle();
        host_tx_in            <= 1'b1;
        exp_tx_in             <= 1'b1;
        channel1_disable      <= 1'b0;
        channel2_disable      <= 1'b0;
        over_temp             <= 1'b0;
        battery_short_detect1 <= 1'b0;
        battery_short_detect2 <= 1'b0;
        ext1_n                <= 1'b1;
        ext2_n                <= 1'b1;
        tick(8);
        check("idle", outs(), 7'h70);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Whole run is under a thousand cycles; twenty times that means a hang
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        stop_test();
    end

    initial
    begin
        logic [31:0] lfsr;
        logic [3:0]  hist0;
        logic [3:0]  hist1;
        int          toggles;
        logic        last;
        err_total = 0;
        num_checks = 0;
        lfsr = 32'h842efbab;
        hist0 = 4'hc;
        hist1 = 4'hc;
        rst = 1'b1;
        {host_tx_in, exp_tx_in, channel1_disable, channel2_disable} = 4'hc;
        {over_temp, battery_short_detect1, battery_short_detect2} = 3'h0;
        {ext1_n, ext2_n} = 2'h3;
        tick(3);
        host_tx_in <= 1'b0;
        tick(6);
        check("reset", outs(), 7'h30);
        tick(1);
        rst <= 1'b0;
        idle();
        host_tx_in <= 1'b0;
        tick(4);
        check("host", outs(), 7'h4c);
        idle();
        exp_tx_in <= 1'b0;
        tick(4);
        check("exp", outs(), 7'h5c);
        idle();
        for (int ch = 1; ch <= 2; ch++)
        begin
            ext1_n <= (ch != 1);
            ext2_n <= (ch != 2);
            tick(6);
            check("bus", outs(), (ch == 1) ? 7'h44 : 7'h48);
            idle();
            battery_short_detect1 <= (ch == 1);
            battery_short_detect2 <= (ch == 2);
            host_tx_in <= 1'b0;
            tick(DB_CYC + 6);
            check("short", outs(), (ch == 1) ? 7'h44 : 7'h48);
            idle();
        end
        ext1_n <= 1'b0;
        ext2_n <= 1'b0;
        tick(6);
        ext1_n <= 1'b1;
        tick(2);
        ext2_n <= 1'b1;
        tick(2);
        check("block", {6'h0, bus1_drive}, 7'h00);
        toggles = 0;
        last = host_rx_out;
        repeat (12)
        begin
            tick(1);
            if (host_rx_out !== last)
                toggles++;
            last = host_rx_out;
        end
        check("skew", toggles[6:0], 7'h01);
        idle();
        channel1_disable <= 1'b1;
        host_tx_in <= 1'b0;
        tick(4);
        check("dis_tx", outs(), 7'h44);
        host_tx_in <= 1'b1;
        channel2_disable <= 1'b1;
        ext1_n <= 1'b0;
        tick(6);
        check("dis_rx", outs(), 7'h70);
        exp_tx_in <= 1'b0;
        tick(4);
        check("dis_exp", outs(), 7'h50);
        idle();
        host_tx_in <= 1'b0;
        over_temp <= 1'b1;
        tick(4);
        check("hot", outs(), 7'h40);
        idle();
        host_tx_in <= 1'b0;
        tick(TO_CYC - 2);
        check("to_early", outs(), 7'h4c);
        tick(8);
        check("to_late", outs(), 7'h43);
        host_tx_in <= 1'b1;
        tick(4);
        check("to_clear", outs(), 7'h70);
        ext2_n <= 1'b0;
        tick(TO_CYC + 8);
        check("to_bus", outs(), 7'h42);
        idle();
        for (int i = 0; i < 300; i++)
        begin
            if (i > 1)
                check("random", outs(), {2'h2 | {1'b0, hist1[3] & hist1[2]}, hist1[3],
                    drive_exp(hist1[3], hist1[2], hist1[1]),
                    drive_exp(hist1[3], hist1[2], hist1[0]), 2'h0});
            lfsr = lfsr_next(lfsr);
            hist1 = hist0;
            hist0 = {lfsr[0] | lfsr[1], lfsr[2] | lfsr[3] | lfsr[4], lfsr[5] & lfsr[6],
                     lfsr[7] & lfsr[8]};
            {host_tx_in, exp_tx_in, channel1_disable, channel2_disable} <= hist0;
            tick(1);
        end
        stop_test();
    end
endmodule
